/* File: rtl/cpm_pkg.sv */
// package for the configurable pin function mux
// ---------------------------------------------------------------
// Operation
// - each of four pins carries one selectable function; all options on all pins
// - tri-state option keeps the pin driver disabled always
// - rs485 enable asserts while the uart transmitter is sending
// - power enable low once configured, high during suspend
// - tx activity led pulses low on usb transmit
// - rx activity led pulses low on usb receive
// - traffic led pulses low on transmit or receive
// - suspend indicator low while suspended, high otherwise
// - clock outputs 24, 12, 6 mhz, stopped during suspend
// - gpio option gives individually configured bit-bang lines
// - charger detect drives high when a dedicated charger is attached
// - inverted charger detect drives the complement
// - write strobe option outputs the bit-bang write strobe
// - read strobe option outputs the bit-bang read strobe
// - bus power sense is an input used to detect vbus
// - frame toggle inverts on every start-of-frame
// - suspend inhibit input blocks suspend entry while asserted low
// - defaults: rs485 enable, rx led, tx led, suspend indicator
// - input pins weakly pulled up, optionally pulled low in suspend
// ---------------------------------------------------------------
package cpm_pkg;
	localparam int CPM_PINS = 4;
	localparam int CPM_SEL_W = 5;

	typedef enum logic [4:0] {
		CPM_TRISTATE = 5'h00,
		CPM_DRIVE_1 = 5'h01,
		CPM_DRIVE_0 = 5'h02,
		CPM_RS485_TX_ENABLE = 5'h03,
		CPM_POWER_ENABLE_N = 5'h04,
		CPM_TX_ACTIVITY_LED_N = 5'h05,
		CPM_RX_ACTIVITY_LED_N = 5'h06,
		CPM_TRAFFIC_LED_N = 5'h07,
		CPM_SUSPEND_INDICATOR_N = 5'h08,
		CPM_CLOCK_OUT_FAST = 5'h09,
		CPM_CLOCK_OUT_MID = 5'h0a,
		CPM_CLOCK_OUT_SLOW = 5'h0b,
		CPM_GPIO = 5'h0c,
		CPM_CHARGER_DETECT = 5'h0d,
		CPM_CHARGER_DETECT_N = 5'h0e,
		CPM_PARALLEL_WRITE_STROBE_N = 5'h0f,
		CPM_PARALLEL_READ_STROBE_N = 5'h10,
		CPM_BUS_POWER_SENSE = 5'h11,
		CPM_FRAME_TOGGLE = 5'h12,
		CPM_SUSPEND_INHIBIT_N = 5'h13
	} cpm_func_t;

	// register map (byte addresses)
	localparam logic [11:0] CPM_SEL_OFF = 12'h000;
	localparam logic [11:0] CPM_CTRL_OFF = 12'h004;
	localparam logic [11:0] CPM_GPIO_OFF = 12'h008;
	localparam logic [11:0] CPM_STAT_OFF = 12'h00c;
	localparam logic [11:0] CPM_PIN_OFF = 12'h010;

	// field positions
	localparam int CPM_SEL_STRIDE = 8;
	localparam int CPM_CTRL_PULLDN = 0;
	localparam int CPM_GPIO_OE_POS = 4;

	// reset values
	localparam logic [31:0] CPM_SEL_RST = 32'h08050603;
	localparam logic [31:0] CPM_CTRL_RST = 32'h00000000;
	localparam logic [7:0] CPM_GPIO_RST = 8'h00;

	// led stretch time and clock rates
	localparam int CPM_CLK_MHZ = 100;
	localparam int CPM_LED_MS = 4;
	localparam int CPM_LED_CYCLES = CPM_LED_MS * 1000 * CPM_CLK_MHZ;
	localparam int CPM_LED_W = 24;
	localparam int CPM_CLK_DIV_W = 4;

	typedef struct packed {
		logic uart_tx_busy;
		logic configured;
		logic suspended;
		logic usb_tx_event;
		logic usb_rx_event;
		logic sof_event;
		logic charger_attached;
		logic bb_write_strobe_n;
		logic bb_read_strobe_n;
		logic clk_fast;
		logic clk_mid;
		logic clk_slow;
	} cpm_core_t;

	typedef struct packed {
		logic [CPM_PINS-1:0] o;
		logic [CPM_PINS-1:0] oe;
		logic [CPM_PINS-1:0] pull_up;
		logic [CPM_PINS-1:0] pull_down;
	} cpm_pad_t;
endpackage

/* File: rtl/cpm_led_stretch.sv */
// retriggerable low pulse stretcher for activity leds
`timescale 1ns/1ps
module cpm_led_stretch #(
	parameter int CYCLES = cpm_pkg::CPM_LED_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic trigger,
	output logic led_n
);
	import cpm_pkg::*;

	typedef struct packed {
		logic [CPM_LED_W-1:0] count;
		logic led_n;
	} cpm_led_state_t;

	localparam logic [CPM_LED_W-1:0] LOAD = CPM_LED_W'(CYCLES - 1);

	cpm_led_state_t state_reg;
	cpm_led_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (trigger)
		begin
			state_next.count = LOAD;
			state_next.led_n = 1'b0;
		end
		else if (state_reg.count != '0)
		begin
			state_next.count = state_reg.count - 1'b1;
		end
		else
		begin
			state_next.led_n = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= '{count: '0, led_n: 1'b1};
		else
			state_reg <= state_next;
	end

	assign led_n = state_reg.led_n;
endmodule

/* File: rtl/cpm_pin_mux.sv */
// function mux for the four configurable pins with apb configuration
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module cpm_pin_mux #(
	parameter int LED_CYCLES = cpm_pkg::CPM_LED_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cpm_pkg::cpm_core_t core,
	input wire logic [cpm_pkg::CPM_PINS-1:0] config_pins_in,
	output cpm_pkg::cpm_pad_t config_pins_pad,
	output logic bus_power_present,
	output logic suspend_inhibit,
	output logic [cpm_pkg::CPM_PINS-1:0] gpio_in
);
	import cpm_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0] sel;
		logic [31:0] ctrl;
		logic [7:0] gpio;
		logic [31:0] rdata;
		logic err;
		logic frame;
		logic [CPM_PINS-1:0] o;
		logic [CPM_PINS-1:0] oe;
		logic [CPM_PINS-1:0] pu;
		logic [CPM_PINS-1:0] pd;
		logic [CPM_PINS-1:0] gin;
		logic vbus;
		logic inhibit;
	} cpm_state_t;

	cpm_state_t state_reg;
	cpm_state_t state_next;

	logic tx_led_n;
	logic rx_led_n;
	logic traffic_led_n;

	function automatic logic [31:0] cpm_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		return r;
	endfunction

	function automatic cpm_func_t cpm_pin_func(input logic [31:0] sel, input int p);
		return cpm_func_t'(sel[p*CPM_SEL_STRIDE +: CPM_SEL_W]);
	endfunction

	// ---------------------------------------------------------------
	// led stretchers
	// ---------------------------------------------------------------
	cpm_led_stretch #(.CYCLES(LED_CYCLES)) u_tx_led (
		.pclk(pclk),
		.presetn(presetn),
		.trigger(core.usb_tx_event),
		.led_n(tx_led_n)
	);

	cpm_led_stretch #(.CYCLES(LED_CYCLES)) u_rx_led (
		.pclk(pclk),
		.presetn(presetn),
		.trigger(core.usb_rx_event),
		.led_n(rx_led_n)
	);

	cpm_led_stretch #(.CYCLES(LED_CYCLES)) u_traffic_led (
		.pclk(pclk),
		.presetn(presetn),
		.trigger(core.usb_tx_event | core.usb_rx_event),
		.led_n(traffic_led_n)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic setup;
		logic is_in;
		logic vb;
		logic inh;
		cpm_func_t f;
		logic [31:0] merged;
		setup = 1'b0;
		is_in = 1'b0;
		vb = 1'b0;
		inh = 1'b0;
		f = CPM_TRISTATE;
		merged = '0;
		state_next = state_reg;

		// apb: answer in setup cycle so access phase completes at once
		setup = psel && !penable;
		if (setup)
		begin
			state_next.err = 1'b0;
			state_next.rdata = '0;
			case (paddr)
				CPM_SEL_OFF:
				begin
					if (pwrite)
						state_next.sel = cpm_merge(state_reg.sel, pwdata, pstrb);
					state_next.rdata = state_reg.sel;
				end
				CPM_CTRL_OFF:
				begin
					if (pwrite)
					begin
						// only the pull-down enable bit is kept
						merged = cpm_merge(state_reg.ctrl, pwdata, pstrb);
						state_next.ctrl = '0;
						state_next.ctrl[CPM_CTRL_PULLDN] = merged[CPM_CTRL_PULLDN];
					end
					state_next.rdata = state_reg.ctrl;
				end
				CPM_GPIO_OFF:
				begin
					if (pwrite && pstrb[0])
						state_next.gpio = pwdata[7:0];
					state_next.rdata = {24'h0, state_reg.gpio};
				end
				CPM_STAT_OFF:
				begin
					state_next.rdata = {24'h0, state_reg.gin, 2'b00, state_reg.inhibit,
						state_reg.vbus};
					state_next.err = pwrite;
				end
				CPM_PIN_OFF:
				begin
					state_next.rdata = {16'h0, state_reg.o, state_reg.oe, state_reg.pu,
						state_reg.pd};
					state_next.err = pwrite;
				end
				default:
				begin
					state_next.err = 1'b1;
				end
			endcase
		end

		// frame-start square wave
		if (core.sof_event)
			state_next.frame = !state_reg.frame;

		for (int p = 0; p < CPM_PINS; p++)
		begin
			f = cpm_pin_func(state_reg.sel, p);
			is_in = 1'b0;
			state_next.o[p] = 1'b0;
			state_next.oe[p] = 1'b1;
			case (f)
				CPM_TRISTATE:
				begin
					state_next.oe[p] = 1'b0;
				end
				CPM_DRIVE_1:
					state_next.o[p] = 1'b1;
				CPM_DRIVE_0:
					state_next.o[p] = 1'b0;
				CPM_RS485_TX_ENABLE:
					state_next.o[p] = core.uart_tx_busy;
				CPM_POWER_ENABLE_N:
					state_next.o[p] = !(core.configured && !core.suspended);
				CPM_TX_ACTIVITY_LED_N:
					state_next.o[p] = tx_led_n;
				CPM_RX_ACTIVITY_LED_N:
					state_next.o[p] = rx_led_n;
				CPM_TRAFFIC_LED_N:
					state_next.o[p] = traffic_led_n;
				CPM_SUSPEND_INDICATOR_N:
					state_next.o[p] = !core.suspended;
				CPM_CLOCK_OUT_FAST:
					state_next.o[p] = core.clk_fast && !core.suspended;
				CPM_CLOCK_OUT_MID:
					state_next.o[p] = core.clk_mid && !core.suspended;
				CPM_CLOCK_OUT_SLOW:
					state_next.o[p] = core.clk_slow && !core.suspended;
				CPM_GPIO:
				begin
					// per-pin direction and level from the gpio register
					state_next.oe[p] = state_reg.gpio[CPM_GPIO_OE_POS + p];
					state_next.o[p] = state_reg.gpio[p];
					is_in = !state_reg.gpio[CPM_GPIO_OE_POS + p];
				end
				CPM_CHARGER_DETECT:
					state_next.o[p] = core.charger_attached;
				CPM_CHARGER_DETECT_N:
					state_next.o[p] = !core.charger_attached;
				CPM_PARALLEL_WRITE_STROBE_N:
					state_next.o[p] = core.bb_write_strobe_n;
				CPM_PARALLEL_READ_STROBE_N:
					state_next.o[p] = core.bb_read_strobe_n;
				CPM_BUS_POWER_SENSE:
				begin
					state_next.oe[p] = 1'b0;
					is_in = 1'b1;
					vb = vb | config_pins_in[p];
				end
				CPM_FRAME_TOGGLE:
					state_next.o[p] = state_reg.frame;
				CPM_SUSPEND_INHIBIT_N:
				begin
					state_next.oe[p] = 1'b0;
					is_in = 1'b1;
					inh = inh | !config_pins_in[p];
				end
				default:
				begin
					state_next.oe[p] = 1'b0;
				end
			endcase
			// input pins: weak pull-up, or weak pull-down in suspend when enabled
			state_next.pd[p] = is_in && state_reg.ctrl[CPM_CTRL_PULLDN] && core.suspended;
			state_next.pu[p] = is_in && !state_next.pd[p];
			state_next.gin[p] = (f == CPM_GPIO) ? config_pins_in[p] : 1'b0;
		end
		state_next.vbus = vb;
		state_next.inhibit = inh;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
			state_reg.sel <= CPM_SEL_RST;
			state_reg.ctrl <= CPM_CTRL_RST;
			state_reg.gpio <= CPM_GPIO_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign pready = psel && penable;
	assign prdata = state_reg.rdata;
	assign pslverr = psel && penable && state_reg.err;
	assign config_pins_pad.o = state_reg.o;
	assign config_pins_pad.oe = state_reg.oe;
	assign config_pins_pad.pull_up = state_reg.pu;
	assign config_pins_pad.pull_down = state_reg.pd;
	assign bus_power_present = state_reg.vbus;
	assign suspend_inhibit = state_reg.inhibit;
	assign gpio_in = state_reg.gin;
endmodule

/* File: verification/cpm_pin_mux_checker.sv */
// concurrent checks on the pin function mux ports
`timescale 1ns/1ps
module cpm_pin_mux_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire cpm_pkg::cpm_core_t core,
	input wire logic [cpm_pkg::CPM_PINS-1:0] config_pins_in,
	input wire cpm_pkg::cpm_pad_t config_pins_pad,
	input wire logic bus_power_present,
	input wire logic suspend_inhibit
);
	import cpm_pkg::*;
	logic [4:0] sel_q;
	logic up_q;
	wire logic [3:0] o = config_pins_pad.o;
	wire logic [3:0] oe = config_pins_pad.oe;
	// shadow of the pin 0 function, armed one cycle after reset
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sel_q <= CPM_SEL_RST[4:0];
			up_q <= 1'h0;
		end
		else
		begin
			up_q <= 1'h1;
			if (psel && !penable && pwrite && paddr == CPM_SEL_OFF && pstrb[0])
				sel_q <= pwdata[4:0];
		end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence on(logic [4:0] f);
		up_q && $past(sel_q) == f;
	endsequence
	sequence hit(logic [4:0] f, logic ev);
		up_q && sel_q == f && ev;
	endsequence
	tri_off_a: assert property (on(CPM_TRISTATE) |-> !oe[0])
		else $error("pin driven");
	drive_one_a: assert property (on(CPM_DRIVE_1) |-> oe[0] && o[0])
		else $error("bad level");
	drive_zero_a: assert property (on(CPM_DRIVE_0) |-> oe[0] && !o[0])
		else $error("bad level");
	rs485_en_a: assert property (on(CPM_RS485_TX_ENABLE) |-> o[0] == $past(core.uart_tx_busy))
		else $error("bad enable");
	power_en_a: assert property (on(CPM_POWER_ENABLE_N) |->
		o[0] == !($past(core.configured) && !$past(core.suspended)))
		else $error("bad power");
	suspend_out_a: assert property (on(CPM_SUSPEND_INDICATOR_N) |-> o[0] == !$past(core.suspended))
		else $error("bad suspend");
	clock_gate_a: assert property (on(CPM_CLOCK_OUT_FAST) |->
		o[0] == ($past(core.clk_fast) && !$past(core.suspended)))
		else $error("bad clock");
	charger_a: assert property (on(CPM_CHARGER_DETECT) |-> o[0] == $past(core.charger_attached))
		else $error("bad charger");
	charger_inv_a: assert property (on(CPM_CHARGER_DETECT_N) |-> o[0] != $past(core.charger_attached))
		else $error("bad charger");
	write_strobe_a: assert property (on(CPM_PARALLEL_WRITE_STROBE_N) |->
		o[0] == $past(core.bb_write_strobe_n))
		else $error("bad strobe");
	sense_input_a: assert property (on(CPM_BUS_POWER_SENSE) |->
		!oe[0] && (!$past(config_pins_in[0]) || bus_power_present))
		else $error("bad sense");
	inhibit_input_a: assert property (on(CPM_SUSPEND_INHIBIT_N) |->
		!oe[0] && ($past(config_pins_in[0]) || suspend_inhibit))
		else $error("bad inhibit");
	led_pulse_a: assert property (hit(CPM_TX_ACTIVITY_LED_N, core.usb_tx_event) |->
		##[1:3] !o[0])
		else $error("no pulse");
	frame_flip_a: assert property (hit(CPM_FRAME_TOGGLE, core.sof_event) |->
		##[1:3] $changed(o[0]))
		else $error("no toggle");
endmodule
bind cpm_pin_mux cpm_pin_mux_checker cpm_pin_mux_checker_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .core(core), .config_pins_in(config_pins_in),
	.config_pins_pad(config_pins_pad), .bus_power_present(bus_power_present),
	.suspend_inhibit(suspend_inhibit));

/* File: verification/cpm_far_model.sv */
// external logic on the four configurable pins
`timescale 1ns/1ps
module cpm_far_model (
	input wire logic pclk,
	input wire cpm_pkg::cpm_pad_t pad,
	input wire logic [3:0] drv,
	input wire logic [3:0] val,
	output logic [3:0] pins
);
	import cpm_pkg::*;
	logic flip = 1'h0;
	always @(posedge pclk)
		flip <= !flip;
	// undriven and unpulled pins wander every cycle
	always_comb
		for (int i = 0; i < 4; i++)
			pins[i] = pad.oe[i] ? pad.o[i] : drv[i] ? val[i] : pad.pull_up[i] ? 1'h1 :
				pad.pull_down[i] ? 1'h0 : flip ^ i[0];
endmodule

/* File: verification/cpm_pin_mux_tb.sv */
// testbench for the configurable pin function mux
`timescale 1ns/1ps
module cpm_pin_mux_tb;
	import cpm_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'h0, drv = 4'h0, val = 4'h0, pins, gpio_in;
	logic pready, pslverr, bus_power_present, suspend_inhibit, e, v;
	logic [2:0] x;
	cpm_core_t core = '0;
	cpm_pad_t pad;
	int error_cnt = 0, checks_done = 0;
	always #5 pclk = !pclk;
	cpm_pin_mux #(.LED_CYCLES(8)) cpm_pin_mux_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
		.config_pins_in(pins), .config_pins_pad(pad), .bus_power_present(bus_power_present),
		.suspend_inhibit(suspend_inhibit), .gpio_in(gpio_in));
	cpm_far_model cpm_far_model_inst (.pclk(pclk), .pad(pad), .drv(drv), .val(val), .pins(pins));
	task chk(input logic [31:0] g, input logic [31:0] w);
		checks_done++;
		if (g !== w)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, w);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1)
		begin
			error_cnt++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task pulse(input int b);
		@(posedge pclk);
		core[b] <= 1'h1;
		@(posedge pclk);
		core[b] <= 1'h0;
	endtask
	// expected {output checked, enable, level} for one function
	function automatic logic [2:0] ex(input logic [4:0] f, input cpm_core_t c);
		case (f)
			CPM_DRIVE_1: ex = 3'h7;
			CPM_DRIVE_0: ex = 3'h6;
			CPM_RS485_TX_ENABLE: ex = {2'h3, c.uart_tx_busy};
			CPM_POWER_ENABLE_N: ex = {2'h3, !(c.configured && !c.suspended)};
			CPM_TX_ACTIVITY_LED_N, CPM_RX_ACTIVITY_LED_N, CPM_TRAFFIC_LED_N: ex = 3'h7;
			CPM_SUSPEND_INDICATOR_N: ex = {2'h3, !c.suspended};
			CPM_CLOCK_OUT_FAST: ex = {2'h3, c.clk_fast && !c.suspended};
			CPM_CLOCK_OUT_MID: ex = {2'h3, c.clk_mid && !c.suspended};
			CPM_CLOCK_OUT_SLOW: ex = {2'h3, c.clk_slow && !c.suspended};
			CPM_CHARGER_DETECT: ex = {2'h3, c.charger_attached};
			CPM_CHARGER_DETECT_N: ex = {2'h3, !c.charger_attached};
			CPM_PARALLEL_WRITE_STROBE_N: ex = {2'h3, c.bb_write_strobe_n};
			CPM_PARALLEL_READ_STROBE_N: ex = {2'h3, c.bb_read_strobe_n};
			CPM_FRAME_TOGGLE: ex = 3'h2;
			default: ex = 3'h0;
		endcase
	endfunction
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		tick(3);
		chk(pad.oe, 4'hf);
		chk(pad.o, 4'he);
		apb(1'h0, CPM_SEL_OFF, 32'h0);
		chk(r, 32'h08050603);
		chk(e, 1'h0);
		apb(1'h0, 12'h0fc, 32'h0);
		chk(e, 1'h1);
		apb(1'h1, CPM_STAT_OFF, 32'hff);
		chk(e, 1'h1);
		for (int k = 0; k < 2; k++)
			for (int f = 0; f < 20; f++)
			begin
				@(posedge pclk);
				core <= k ? 12'h616 : 12'hc2d;
				apb(1'h1, CPM_SEL_OFF, {4{3'h0, 5'(f)}});
				tick(3);
				x = ex(5'(f), core);
				chk(pad.oe, {4{x[1]}});
				if (x[2])
					chk(pad.o, {4{x[0]}});
			end
		@(posedge pclk);
		core <= 12'h400;
		apb(1'h1, CPM_SEL_OFF, 32'h00070605);
		pulse(7);
		tick(3);
		chk(pad.o[2:0], 3'h1);
		tick(12);
		chk(pad.o[2:0], 3'h7);
		pulse(8);
		tick(5);
		pulse(8);
		tick(6);
		chk(pad.o[2:0], 3'h2);
		apb(1'h1, CPM_SEL_OFF, 32'h12);
		tick(3);
		v = pad.o[0];
		pulse(6);
		tick(3);
		chk(pad.o[0], !v);
		pulse(6);
		tick(3);
		chk(pad.o[0], v);
		apb(1'h1, CPM_SEL_OFF, 32'h1311);
		drv <= 4'h3;
		val <= 4'h1;
		tick(3);
		chk({bus_power_present, suspend_inhibit}, 2'h3);
		apb(1'h0, CPM_STAT_OFF, 32'h0);
		chk(r, 32'h3);
		@(posedge pclk);
		val <= 4'h2;
		tick(3);
		chk({bus_power_present, suspend_inhibit}, 2'h0);
		@(posedge pclk);
		drv <= 4'h0;
		core <= 12'h200;
		apb(1'h1, CPM_CTRL_OFF, 32'h1);
		tick(3);
		chk({pad.pull_up[1:0], pad.pull_down[1:0]}, 4'h3);
		apb(1'h1, CPM_GPIO_OFF, 32'hf5);
		apb(1'h1, CPM_SEL_OFF, 32'h0c0c0c0c);
		tick(4);
		chk({pad.oe, pad.o, gpio_in}, 12'hf55);
		results();
	end
endmodule
